// ==== rtl/lrg_defines.svh ====
// Constants for the pseudo-random word generator
`ifndef LRG_DEFINES_SVH
`define LRG_DEFINES_SVH
`define LRG_MULT 32'h41c64e6d
`define LRG_INC 32'h00003039
`define LRG_SEED_RESET 32'h00000001
`define LRG_OUT_SHIFT 16
`define LRG_OUT_MASK 32'h00007fff
`define LRG_SEED_MAX 32'h7fffffff
`endif

// ==== rtl/lrg_pkg.sv ====
// Types shared by the pseudo-random word generator
package lrg_pkg;
    typedef logic [31:0] lrg_seed_t;
    typedef logic [15:0] lrg_word_t;
    typedef enum logic [1:0] {LRG_IDLE, LRG_STEP} lrg_state_t;
endpackage : lrg_pkg

// ==== rtl/lrg_step_if.sv ====
// Seed update path between the control and the arithmetic stage
`timescale 1ns/1ps
`default_nettype none
interface lrg_step_if;
    lrg_pkg::lrg_seed_t seed;
    lrg_pkg::lrg_seed_t next_seed;
    lrg_pkg::lrg_word_t value;
    modport ctrl (output seed, input next_seed, input value);
    modport calc (input seed, output next_seed, output value);
endinterface : lrg_step_if
`default_nettype wire

// ==== rtl/lrg_step.sv ====
// Combinational seed update and result extraction
`timescale 1ns/1ps
`default_nettype none
`include "lrg_defines.svh"
module lrg_step (
    lrg_step_if.calc st // Seed in, next seed and value out
);
    // Wrapping unsigned multiply-add
    function automatic lrg_pkg::lrg_seed_t advance(lrg_pkg::lrg_seed_t s);
        logic [63:0] p;
        p = s * `LRG_MULT + `LRG_INC;
        return p[31:0]; // [RULE_08]
    endfunction : advance

    // Value taken from the fresh state
    function automatic lrg_pkg::lrg_word_t extract(lrg_pkg::lrg_seed_t s);
        lrg_pkg::lrg_seed_t m;
        m = (s >> `LRG_OUT_SHIFT) & `LRG_OUT_MASK;
        return m[15:0];
    endfunction : extract

    // Next state and its output word
    assign st.next_seed = advance(st.seed); // [RULE_01]
    assign st.value = extract(st.next_seed); // [RULE_03] [RULE_02]
endmodule : lrg_step
`default_nettype wire

// ==== rtl/lrg_gen.sv ====
// Pseudo-random word generator with a linear congruential seed
// Contract
// (RULE_01) Each execution: seed times constant plus increment
// (RULE_02) Output always between 0 and 32767
// (RULE_03) Output is new seed shifted 16, masked
// (RULE_04) Seed loaded once at stop-to-run change
// (RULE_05) Seed starts at one after power-up
// (RULE_06) Result written as one 16-bit word
// (RULE_07) Pulse form: one value per rising command
// (RULE_08) Arithmetic unsigned, wraps modulo two^32
`timescale 1ns/1ps
`default_nettype none
`include "lrg_defines.svh"
module lrg_gen (
    input wire logic mclk, // System clock, 50 MHz
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic run_mode, // High while the controller runs
    input wire logic [31:0] seed_in, // Seed offered at stop-to-run
    input wire logic seed_load, // Request to load seed_in
    input wire logic pseudo_random_generate, // Continuous execute level
    input wire logic pseudo_random_generate_pulse, // Edge-triggered command
    output logic [15:0] result, // Last generated word
    output logic result_valid, // One-cycle write strobe
    output logic [15:0] seed_state_low_word, // Seed bits 15:0
    output logic [15:0] seed_state_high_word // Seed bits 31:16
);
    logic rst_meta;
    logic rst_sync_n;
    lrg_pkg::lrg_seed_t seed;
    logic run_prev;
    logic cmd_prev;
    logic run_rise;
    logic exec;
    logic seed_loaded;
    logic gen_fire;
    lrg_pkg::lrg_state_t run_state;
    lrg_pkg::lrg_state_t next_run_state;
    lrg_step_if st ();

    // Reset release synchroniser
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    lrg_step u_lrg_step (
        .st(st)
    );
    assign st.seed = seed;

    // Edge history of mode and pulse command
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            run_prev <= 1'b0;
            cmd_prev <= 1'b0;
        end else begin
            run_prev <= run_mode;
            cmd_prev <= pseudo_random_generate_pulse;
        end
    end

    assign run_rise = run_mode & ~run_prev;
    // Execute while running: level form or rising pulse command
    assign exec = run_mode & (pseudo_random_generate |
        (pseudo_random_generate_pulse & ~cmd_prev)); // [RULE_07]

    // A load in the stop-to-run cycle wins over an execute there
    assign gen_fire = exec & ~(run_rise & seed_load); // [RULE_04]

    // Seed may be loaded only in the stop-to-run cycle, once
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            seed_loaded <= 1'b0;
        end else if (!run_mode) begin
            seed_loaded <= 1'b0;
        end else if (run_rise && seed_load) begin
            seed_loaded <= 1'b1; // [RULE_04]
        end
    end

    // Run phase: idle while stopped, step once the run is under way
    always_comb begin
        next_run_state = run_state;
        case (run_state)
            lrg_pkg::LRG_IDLE: begin
                if (run_mode) begin
                    next_run_state = lrg_pkg::LRG_STEP;
                end
            end
            lrg_pkg::LRG_STEP: begin
                if (!run_mode) begin
                    next_run_state = lrg_pkg::LRG_IDLE;
                end
            end
            default: begin
                next_run_state = lrg_pkg::LRG_IDLE;
            end
        endcase
    end

    // Run phase register
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            run_state <= lrg_pkg::LRG_IDLE;
        end else begin
            run_state <= next_run_state;
        end
    end

    // Seed state: reset to one, load clipped non-negative, else advance
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            seed <= `LRG_SEED_RESET; // [RULE_05]
        end else if (run_rise && seed_load && !seed_loaded) begin
            seed <= seed_in & `LRG_SEED_MAX; // [RULE_04]
        end else if (exec) begin
            seed <= st.next_seed; // [RULE_01] [RULE_08]
        end
    end

    // Destination word and its strobe
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            result <= 16'h0000;
            result_valid <= 1'b0;
        end else begin
            result_valid <= gen_fire;
            if (gen_fire) begin
                result <= st.value; // [RULE_06] [RULE_03]
            end
        end
    end

    assign seed_state_low_word = seed[15:0];
    assign seed_state_high_word = seed[31:16];

    // Seed one cycle after an execute equals the update of the old seed
    property seed_step_p;
        @(posedge mclk) disable iff (!rst_sync_n)
        gen_fire |=>
            seed == $past(seed) * `LRG_MULT + `LRG_INC;
    endproperty
    seed_update_a: assert property (seed_step_p) // [RULE_01]
        else $error("seed did not advance by the update");

    result_range_a: assert property (@(posedge mclk) // [RULE_02]
        disable iff (!rst_sync_n) result <= 16'h7fff)
        else $error("result above 32767");

    result_from_seed_a: assert property (@(posedge mclk) // [RULE_03]
        disable iff (!rst_sync_n) result_valid |->
            result == 16'((seed >> `LRG_OUT_SHIFT) & `LRG_OUT_MASK))
        else $error("result not taken from fresh seed");

    seed_load_a: assert property (@(posedge mclk) // [RULE_04]
        disable iff (!rst_sync_n)
        (run_rise && seed_load && !seed_loaded) |=>
            seed == ($past(seed_in) & `LRG_SEED_MAX))
        else $error("seed load not taken");

    reset_seed_a: assert property (@(posedge mclk) // [RULE_05]
        $rose(rst_sync_n) |-> seed == `LRG_SEED_RESET)
        else $error("seed not one after reset");

    sequence pulse_rise_s;
        run_mode && !pseudo_random_generate &&
            $rose(pseudo_random_generate_pulse);
    endsequence
    sequence pulse_hold_s;
        pseudo_random_generate_pulse && !pseudo_random_generate && run_mode;
    endsequence
    pulse_once_a: assert property (@(posedge mclk) // [RULE_07]
        disable iff (!rst_sync_n)
        ((pulse_rise_s and !run_rise) ##1 pulse_hold_s) |-> !exec)
        else $error("held pulse command gave a second value");

    // A rising pulse command while running executes at once
    pulse_fires_a: assert property (@(posedge mclk) // [RULE_07]
        disable iff (!rst_sync_n) pulse_rise_s |-> exec)
        else $error("rising pulse command gave no value");

    // Word holds between write strobes
    result_hold_a: assert property (@(posedge mclk) // [RULE_06]
        disable iff (!rst_sync_n) !result_valid |-> $stable(result))
        else $error("result changed without a write strobe");

    // Each strobe answers an execute one edge earlier
    strobe_cause_a: assert property (@(posedge mclk) // [RULE_07]
        disable iff (!rst_sync_n) result_valid |-> $past(gen_fire))
        else $error("write strobe without an execute");

    // Nothing is generated while stopped
    stopped_quiet_a: assert property (@(posedge mclk) // [RULE_07]
        disable iff (!rst_sync_n) !run_mode |=> !result_valid)
        else $error("value generated while stopped");

    // A load cycle gives no word and leaves a non-negative seed
    load_quiet_a: assert property (@(posedge mclk) // [RULE_04]
        disable iff (!rst_sync_n)
        (run_rise && seed_load) |=> !result_valid && !seed[31])
        else $error("load cycle gave a word or a negative seed");

    // The loaded-once flag never outlives the run it was set in
    run_window_a: assert property (@(posedge mclk) // [RULE_04]
        disable iff (!rst_sync_n)
        (run_state == lrg_pkg::LRG_IDLE) |-> !seed_loaded)
        else $error("load flag set while stopped");

    // Walk of one execute: strobe on the next edge, gone one later
    sequence fire_s;
        gen_fire ##1 !gen_fire;
    endsequence
    sequence strobe_drop_s;
        result_valid ##1 !result_valid;
    endsequence
    strobe_ends_a: assert property (@(posedge mclk) // [RULE_06]
        disable iff (!rst_sync_n) fire_s |-> strobe_drop_s)
        else $error("write strobe did not stand one cycle");

    strobe_follows_a: assert property (@(posedge mclk) // [RULE_06]
        disable iff (!rst_sync_n)
        (exec && !run_rise) |=> result_valid)
        else $error("no write strobe after execute");

    idle_hold_a: assert property (@(posedge mclk) // [RULE_08]
        disable iff (!rst_sync_n)
        (!exec && !run_rise) |=> $stable(seed))
        else $error("seed changed without execute");
endmodule : lrg_gen
`default_nettype wire

// ==== sim/lrg_ctrl_model.sv ====
// Controller model issuing seeds and execute commands
`timescale 1ns/1ps
`default_nettype none
module lrg_ctrl_model (
    input wire logic mclk, // System clock
    output logic run_mode, // Run level
    output logic [31:0] seed_in, // Seed offered
    output logic seed_load, // Seed load request
    output logic level_cmd, // Continuous execute
    output logic pulse_cmd // Edge execute
);
    // Stopped and idle at time zero
    initial begin
        {run_mode, seed_load, level_cmd, pulse_cmd} = 4'h0;
        seed_in = 32'h5a5a5a5a;
    end
    // Stop to run; a seed is offered in that first cycle only
    task start(input logic ld, input logic [31:0] s);
        @(posedge mclk) #1;
        run_mode = 1'b1;
        seed_load = ld;
        seed_in = s & 32'h7fffffff;
        @(posedge mclk) #1;
        seed_load = 1'b0;
        seed_in = ~seed_in; // Not held after the load
    endtask : start
    task stop();
        @(posedge mclk) #1;
        run_mode = 1'b0;
    endtask : stop
    // Hold one command for n cycles; a pulse counts once
    task cmd(input logic lvl, input int n);
        @(posedge mclk) #1;
        if (lvl) level_cmd = 1'b1;
        else pulse_cmd = 1'b1;
        repeat (n) @(posedge mclk);
        #1;
        {level_cmd, pulse_cmd} = 2'h0;
    endtask : cmd
endmodule : lrg_ctrl_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the pseudo-random word generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk, rstn, run_mode, seed_load, level_cmd, pulse_cmd;
    logic [31:0] seed_in, exp_seed, exp_word;
    logic [15:0] result, lo, hi;
    logic result_valid;
    int n_fail = 0, tests_run = 0, n_valid = 0, base;
    lrg_gen u_lrg_gen (.mclk(mclk), .rstn(rstn), .run_mode(run_mode),
        .seed_in(seed_in), .seed_load(seed_load),
        .pseudo_random_generate(level_cmd),
        .pseudo_random_generate_pulse(pulse_cmd), .result(result),
        .result_valid(result_valid), .seed_state_low_word(lo),
        .seed_state_high_word(hi));
    lrg_ctrl_model u_lrg_ctrl_model (.mclk(mclk), .run_mode(run_mode),
        .seed_in(seed_in), .seed_load(seed_load), .level_cmd(level_cmd),
        .pulse_cmd(pulse_cmd));
    // Clock at 50 MHz
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Reference step, wrapping at 32 bits
    function automatic logic [31:0] step(input logic [31:0] s);
        return s * 32'h41c64e6d + 32'h00003039;
    endfunction : step
    // On every strobe advance the reference and compare word and seed
    always @(posedge mclk) begin
        #2;
        if (result_valid === 1'b1) begin
            exp_seed = step(exp_seed);
            n_valid++;
            check("seed", {hi, lo}, exp_seed);
            exp_word = (exp_seed >> 16) & 32'h7fff;
            check("word", {16'h0, result}, exp_word);
            check("range", {31'h0, result[15]}, 32'h0);
        end
    end
    // Issue a command and count the strobes it gives
    task run_cmd(input logic lvl, input int n, input int want);
        base = n_valid;
        u_lrg_ctrl_model.cmd(lvl, n);
        repeat (3) @(posedge mclk);
        #3;
        check("strobes", n_valid - base, want);
    endtask : run_cmd
    task t_reset();
        check("reset seed", {hi, lo}, 32'h1);
        check("reset word", {16'h0, result}, 32'h0);
        u_lrg_ctrl_model.start(1'b0, 32'h0);
        run_cmd(1'b0, 1, 1);
        $display("test reset done");
    endtask : t_reset
    // Top seed, bit 31 masked off by the model; held pulse, then level back to back
    task t_pulse();
        u_lrg_ctrl_model.stop();
        exp_seed = 32'h7fffffff;
        u_lrg_ctrl_model.start(1'b1, 32'hffffffff);
        run_cmd(1'b0, 5, 1);
        run_cmd(1'b1, 4, 4);
        $display("test pulse done");
    endtask : t_pulse
    // Commands while stopped are refused; seed kept without a load
    task t_stopped();
        u_lrg_ctrl_model.stop();
        run_cmd(1'b1, 3, 0);
        run_cmd(1'b0, 2, 0);
        u_lrg_ctrl_model.start(1'b0, 32'h0);
        run_cmd(1'b0, 1, 1);
        $display("test stopped done");
    endtask : t_stopped
    // Load and level execute in the same stop-to-run cycle: load wins
    task t_load_wins();
        u_lrg_ctrl_model.stop();
        exp_seed = 32'h00000005;
        base = n_valid;
        fork
            u_lrg_ctrl_model.start(1'b1, 32'h00000005);
            u_lrg_ctrl_model.cmd(1'b1, 3);
        join
        repeat (3) @(posedge mclk);
        #3;
        check("load strobes", n_valid - base, 2);
        $display("test load done");
    endtask : t_load_wins
    // Reset in mid-run: seed back to one, word cleared, run resumes
    task t_rerun();
        @(posedge mclk) #1;
        rstn = 1'b0;
        exp_seed = 32'h1;
        repeat (2) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge mclk);
        #3;
        check("rerun seed", {hi, lo}, 32'h1);
        check("rerun word", {16'h0, result}, 32'h0);
        run_cmd(1'b0, 1, 1);
        $display("test rerun done");
    endtask : t_rerun
    task wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    // Reset for 4 cycles, then the tests
    initial begin
        rstn = 1'b0;
        exp_seed = 32'h1;
        repeat (4) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge mclk);
        t_reset();
        t_pulse();
        t_stopped();
        t_load_wins();
        t_rerun();
        wrap_up();
    end
    // Tests need under 200 cycles; 5000 cycles means a hang
    initial begin
        #100000;
        n_fail++;
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
